// ### rtl/icn_cfg.svh
// Constants of the input change notification block.
// Assumes word-indexed registers on a plain strobe port.
`ifndef ICN_CFG_SVH
`define ICN_CFG_SVH
// ==========================================
// Register word indexes
`define ICN_ADDR_W     8
`define ICN_DATA_W     16
`define ICN_SPAN_W     48
`define ICN_OFS_EN     8'h00
`define ICN_OFS_PU     8'h03
`define ICN_OFS_PD     8'h06
`define ICN_OFS_STAT   8'h09
`define ICN_OFS_MASK   8'h0a
`define ICN_OFS_LVL    8'h0b
`define ICN_GRP_WORDS  8'h03
// ==========================================
// Status and mask bit positions
`define ICN_BIT_CHG    0
`define ICN_BIT_WAKE   1
`define ICN_BIT_PULL   2
`define ICN_EVT_W      3
// ==========================================
// Reset values and sizes
`define ICN_RST_WORD   16'h0000
`define ICN_RST_EVT    3'h0
`define ICN_NUM_PINS   37
`endif

// ### rtl/icn_pkg.sv
// Types shared by the change notification block.
// Assumes icn_cfg.svh is on the include path.
`include "icn_cfg.svh"
package icn_pkg;
  typedef logic [`ICN_ADDR_W-1:0] icn_addr_t;
  typedef logic [`ICN_DATA_W-1:0] icn_data_t;
  typedef logic [`ICN_SPAN_W-1:0] icn_span_t;
  typedef logic [`ICN_EVT_W-1:0]  icn_evt_t;
  typedef struct packed {
    icn_addr_t addr;
    icn_data_t wdata;
    logic      wr;
    logic      rd;
  } icn_bus_req_s;
endpackage : icn_pkg

// ### rtl/icn_top.sv
// Input change notification, pull controls and wake request.
// Assumes pins synchronous to clk_in and a one-cycle strobe master.
//
// How it works
// - A read of the pin level returns the level sampled one cycle earlier, so software waits one cycle after a port write.
// - An interrupt request is raised whenever any selected pin changes state.
// - In sleep a combinational compare against the held reference still requests a wake.
// - Up to 37 change inputs, numbered 0 to 36, the count set by a parameter.
// - Each pin has its own interrupt enable bit and a clear bit never requests.
// - Each pin has its own weak pull-up enable bit.
// - Each pin has its own weak pull-down enable bit, separate from the pull-ups.
`timescale 1ns/1ns
`default_nettype none
`include "icn_cfg.svh"

module icn_top #(
  parameter int NUM_PINS = `ICN_NUM_PINS
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire icn_pkg::icn_bus_req_s  bus_in,
  output logic [`ICN_DATA_W-1:0]      rdata_out,
  input  wire logic [NUM_PINS-1:0]    pins_in,
  input  wire logic                   sleep_in,
  output logic [NUM_PINS-1:0]         pullup_en_out,
  output logic [NUM_PINS-1:0]         pulldown_en_out,
  output logic                        irq_out,
  output logic                        wake_out
);

  // ==========================================
  // Elaboration check
  if (NUM_PINS < 1 || NUM_PINS > `ICN_NUM_PINS) begin : g_bad_pins
    $error("icn_top: NUM_PINS must be 1 to 37");
  end

  if (`ICN_SPAN_W < NUM_PINS) begin : g_bad_span
    $error("icn_top: pin span narrower than NUM_PINS");
  end

  // ==========================================
  // Helpers
  function automatic logic in_group(
    input icn_pkg::icn_addr_t addr,
    input icn_pkg::icn_addr_t base
  );
    in_group = (addr >= base) &&
               (addr < base + `ICN_GRP_WORDS);
  endfunction : in_group

  function automatic int unsigned word_idx(
    input icn_pkg::icn_addr_t addr,
    input icn_pkg::icn_addr_t base
  );
    icn_pkg::icn_addr_t diff;
    diff = addr - base;
    word_idx = int'(diff[1:0]);
  endfunction : word_idx

  function automatic icn_pkg::icn_span_t put_word(
    input icn_pkg::icn_span_t vec,
    input int unsigned        idx,
    input icn_pkg::icn_data_t data
  );
    icn_pkg::icn_span_t res;
    res = vec;
    res[idx*`ICN_DATA_W +: `ICN_DATA_W] = data;
    put_word = res;
  endfunction : put_word

  function automatic icn_pkg::icn_data_t get_word(
    input icn_pkg::icn_span_t vec,
    input int unsigned        idx
  );
    get_word = vec[idx*`ICN_DATA_W +: `ICN_DATA_W];
  endfunction : get_word

  function automatic logic any_set(
    input icn_pkg::icn_span_t vec
  );
    any_set = (vec != '0);
  endfunction : any_set

  // ==========================================
  // Pin span helpers
  localparam icn_pkg::icn_span_t PIN_MASK =
    icn_pkg::icn_span_t'((49'h1 << NUM_PINS) - 49'h1);

  icn_pkg::icn_span_t pins_wide;
  assign pins_wide = icn_pkg::icn_span_t'(pins_in);

  // ==========================================
  // Bus decode
  logic hit_en;
  logic hit_pu;
  logic hit_pd;
  logic hit_lvl;
  logic hit_stat;
  logic hit_mask;
  int unsigned idx_en;
  int unsigned idx_pu;
  int unsigned idx_pd;
  int unsigned idx_lvl;

  assign hit_en   = in_group(bus_in.addr, `ICN_OFS_EN);
  assign hit_pu   = in_group(bus_in.addr, `ICN_OFS_PU);
  assign hit_pd   = in_group(bus_in.addr, `ICN_OFS_PD);
  assign hit_lvl  = in_group(bus_in.addr, `ICN_OFS_LVL);
  assign hit_stat = (bus_in.addr == `ICN_OFS_STAT);
  assign hit_mask = (bus_in.addr == `ICN_OFS_MASK);
  assign idx_en   = word_idx(bus_in.addr, `ICN_OFS_EN);
  assign idx_pu   = word_idx(bus_in.addr, `ICN_OFS_PU);
  assign idx_pd   = word_idx(bus_in.addr, `ICN_OFS_PD);
  assign idx_lvl  = word_idx(bus_in.addr, `ICN_OFS_LVL);

  // Per-register write and clear strobes
  logic wr_en;
  logic wr_pu;
  logic wr_pd;
  logic wr_mask;
  logic clr_stat;

  assign wr_en    = bus_in.wr && hit_en;
  assign wr_pu    = bus_in.wr && hit_pu;
  assign wr_pd    = bus_in.wr && hit_pd;
  assign wr_mask  = bus_in.wr && hit_mask;
  assign clr_stat = bus_in.rd && hit_stat;

  // ==========================================
  // Interrupt enable bits
  icn_pkg::icn_span_t change_irq_enable_reg;
  icn_pkg::icn_span_t change_irq_enable_next;

  always_comb begin
    change_irq_enable_next = change_irq_enable_reg;
    if (wr_en) begin
      change_irq_enable_next = put_word(change_irq_enable_reg,
        idx_en, bus_in.wdata) & PIN_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      change_irq_enable_reg <= '0;
    end else begin
      change_irq_enable_reg <= change_irq_enable_next;
    end
  end

  // ==========================================
  // Pull-up enable bits
  icn_pkg::icn_span_t pullup_enable_reg;
  icn_pkg::icn_span_t pullup_enable_next;

  always_comb begin
    pullup_enable_next = pullup_enable_reg;
    if (wr_pu) begin
      pullup_enable_next = put_word(pullup_enable_reg,
        idx_pu, bus_in.wdata) & PIN_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pullup_enable_reg <= '0;
    end else begin
      pullup_enable_reg <= pullup_enable_next;
    end
  end

  assign pullup_en_out = pullup_enable_reg[NUM_PINS-1:0];

  // ==========================================
  // Pull-down enable bits
  icn_pkg::icn_span_t pulldown_enable_reg;
  icn_pkg::icn_span_t pulldown_enable_next;

  always_comb begin
    pulldown_enable_next = pulldown_enable_reg;
    if (wr_pd) begin
      pulldown_enable_next = put_word(pulldown_enable_reg,
        idx_pd, bus_in.wdata) & PIN_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulldown_enable_reg <= '0;
    end else begin
      pulldown_enable_reg <= pulldown_enable_next;
    end
  end

  assign pulldown_en_out = pulldown_enable_reg[NUM_PINS-1:0];

  // ==========================================
  // Pin sampling and reference
  // Both held in sleep, as the clocks would be stopped
  icn_pkg::icn_span_t pin_sample_reg;
  icn_pkg::icn_span_t pin_prev_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_sample_reg <= '0;
    end else if (!sleep_in) begin
      pin_sample_reg <= pins_wide & PIN_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_prev_reg <= '0;
    end else if (!sleep_in) begin
      pin_prev_reg <= pin_sample_reg;
    end
  end

  // First cycle after reset has no valid reference
  logic ref_valid_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_valid_reg <= 1'b0;
    end else if (!sleep_in) begin
      ref_valid_reg <= 1'b1;
    end
  end

  // ==========================================
  // Change detection
  logic               change_evt;
  logic               wake_evt;
  logic               pull_evt;
  icn_pkg::icn_span_t pin_diff;
  icn_pkg::icn_span_t wake_diff;
  icn_pkg::icn_span_t pull_clash;

  // Enabled pins that moved since the previous sample
  assign pin_diff = (pin_sample_reg ^ pin_prev_reg) &
                    change_irq_enable_reg;

  assign change_evt = !sleep_in && ref_valid_reg &&
                      any_set(pin_diff);

  // Asynchronous compare, needs no clock edge
  assign wake_diff = ((pins_wide & PIN_MASK) ^ pin_sample_reg) &
                     change_irq_enable_reg;

  assign wake_out = sleep_in && ref_valid_reg &&
                    any_set(wake_diff);

  assign wake_evt = wake_out;

  // Flag a pin left with both pulls on
  assign pull_clash = pullup_enable_reg & pulldown_enable_reg;
  assign pull_evt   = any_set(pull_clash);

  // ==========================================
  // Sticky status, cleared by reading it
  icn_pkg::icn_evt_t status_reg;
  icn_pkg::icn_evt_t status_next;
  icn_pkg::icn_evt_t evt_set;

  always_comb begin
    evt_set = `ICN_RST_EVT;
    evt_set[`ICN_BIT_CHG]  = change_evt;
    evt_set[`ICN_BIT_WAKE] = wake_evt;
    evt_set[`ICN_BIT_PULL] = pull_evt;
  end

  always_comb begin
    status_next = status_reg;
    if (clr_stat) begin
      status_next = `ICN_RST_EVT;
    end
    status_next = status_next | evt_set;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_reg <= `ICN_RST_EVT;
    end else begin
      status_reg <= status_next;
    end
  end

  // ==========================================
  // Interrupt mask
  icn_pkg::icn_evt_t mask_reg;
  icn_pkg::icn_evt_t mask_next;

  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = bus_in.wdata[`ICN_EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_reg <= `ICN_RST_EVT;
    end else begin
      mask_reg <= mask_next;
    end
  end

  assign irq_out = |(status_reg & mask_reg);

  // ==========================================
  // Read data, one cycle after the strobe
  icn_pkg::icn_data_t rdata_next;
  icn_pkg::icn_data_t rdata_reg;

  always_comb begin
    rdata_next = `ICN_RST_WORD;
    if (hit_en) begin
      rdata_next = get_word(change_irq_enable_reg, idx_en);
    end else if (hit_pu) begin
      rdata_next = get_word(pullup_enable_reg, idx_pu);
    end else if (hit_pd) begin
      rdata_next = get_word(pulldown_enable_reg, idx_pd);
    end else if (hit_lvl) begin
      rdata_next = get_word(pin_sample_reg, idx_lvl);
    end else if (hit_stat) begin
      rdata_next = icn_pkg::icn_data_t'(status_reg);
    end else if (hit_mask) begin
      rdata_next = icn_pkg::icn_data_t'(mask_reg);
    end
  end

  // Data stand only in the cycle after the read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= `ICN_RST_WORD;
    end else if (bus_in.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `ICN_RST_WORD;
    end
  end

  assign rdata_out = rdata_reg;

endmodule : icn_top

`default_nettype wire

// ### sim/icn_pins_model.sv
// Buttons and loose wires on the change pins.
// Assumes each button shorts its pin against the enabled pull.
`timescale 1ns/1ns
`default_nettype none
module icn_pins_model (
  input  wire logic        clk_in,
  input  wire logic [36:0] pullup_en_in,
  input  wire logic [36:0] pulldown_en_in,
  input  wire logic [36:0] press_in,
  output logic      [36:0] pins_out
);
  // Unpulled pins wander
  logic [36:0] float_reg = '0;
  always_ff @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 37; i++) begin
      if (pullup_en_in[i]) begin
        pins_out[i] = ~press_in[i];
      end else if (pulldown_en_in[i]) begin
        pins_out[i] = press_in[i];
      end else begin
        pins_out[i] = float_reg[i];
      end
    end
  end
endmodule : icn_pins_model
`default_nettype wire

// ### sim/icn_top_checker.sv
// Port assertions for the change notification block.
// Assumes icn_cfg.svh on the include path; bound into icn_top.
`timescale 1ns/1ns
`default_nettype none
`include "icn_cfg.svh"
module icn_top_checker #(
  parameter int NUM_PINS = 37
) (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire icn_pkg::icn_bus_req_s bus_in,
  input wire logic [15:0]           rdata_out,
  input wire logic [NUM_PINS-1:0]   pins_in,
  input wire logic                  sleep_in,
  input wire logic [NUM_PINS-1:0]   pullup_en_out,
  input wire logic [NUM_PINS-1:0]   pulldown_en_out,
  input wire logic                  irq_out,
  input wire logic                  wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Pin history and settings shadows
  logic [NUM_PINS-1:0] d1_reg;
  logic [NUM_PINS-1:0] d2_reg;
  logic                frz_reg;
  logic [1:0]          age_reg;
  logic [15:0]         en_reg;
  logic [2:0]          mask_reg;
  always_ff @(posedge clk_in) begin
    d1_reg <= pins_in;
    d2_reg <= d1_reg;
    frz_reg <= sleep_in ? frz_reg : pins_in[0];
    age_reg <= rst_in ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en_reg <= 16'h0000;
      mask_reg <= 3'h0;
    end else if (bus_in.wr) begin
      en_reg <= (bus_in.addr == `ICN_OFS_EN) ? bus_in.wdata : en_reg;
      mask_reg <= (bus_in.addr == `ICN_OFS_MASK) ? bus_in.wdata[2:0] : mask_reg;
    end
  end
  // ==========================================
  // Assertions
  property p_lvl;
    !sleep_in && !$past(sleep_in) && age_reg == 2'h3 && bus_in.rd && bus_in.addr == `ICN_OFS_LVL
      && pins_in == d1_reg && d1_reg == d2_reg |=> rdata_out == $past(pins_in[15:0]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level read wrong");
  property p_chg;
    !sleep_in && !$past(sleep_in) && age_reg == 2'h3 && en_reg[0] && mask_reg[0]
      && pins_in[0] != d1_reg[0] |-> ##[1:3] irq_out;
  endproperty
  a_chg: assert property (p_chg) else $error("change gave no irq");
  property p_mask;
    mask_reg == 3'h0 |-> !irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq seen");
  property p_wake;
    sleep_in && age_reg == 2'h3 && en_reg[0] && pins_in[0] != frz_reg |-> wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in sleep");
  property p_awake;
    !sleep_in |-> !wake_out;
  endproperty
  a_awake: assert property (p_awake) else $error("wake while awake");
  property p_pu;
    bus_in.wr && bus_in.addr == `ICN_OFS_PU |=> pullup_en_out[15:0] == $past(bus_in.wdata);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up write lost");
  property p_pd;
    bus_in.wr && bus_in.addr == `ICN_OFS_PD |=> pulldown_en_out[15:0] == $past(bus_in.wdata);
  endproperty
  a_pd: assert property (p_pd) else $error("pull-down write lost");
  property p_pdhi;
    bus_in.wr && bus_in.addr == 8'h08
      |=> pulldown_en_out[NUM_PINS-1:32] == $past(bus_in.wdata[NUM_PINS-33:0]);
  endproperty
  a_pdhi: assert property (p_pdhi) else $error("top pins wrong");
  property p_pull;
    mask_reg[2] && (pullup_en_out & pulldown_en_out) != '0 |-> ##[1:2] irq_out;
  endproperty
  a_pull: assert property (p_pull) else $error("pull clash no irq");
endmodule : icn_top_checker
bind icn_top icn_top_checker #(.NUM_PINS(NUM_PINS)) u_icn_top_checker (.clk_in(clk_in),
  .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out), .pins_in(pins_in),
  .sleep_in(sleep_in), .pullup_en_out(pullup_en_out), .pulldown_en_out(pulldown_en_out),
  .irq_out(irq_out), .wake_out(wake_out));
`default_nettype wire

// ### sim/tb_icn_top.sv
// Bench for the change notification block.
// Assumes the pin model and bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
`include "icn_cfg.svh"
module tb_icn_top;
  logic                  clk_in   = 1'b0;
  logic                  rst_in   = 1'b1;
  logic                  sleep_in = 1'b0;
  icn_pkg::icn_bus_req_s bus      = '0;
  logic [36:0]           press    = '0;
  logic [36:0]           pins;
  logic [36:0]           pu;
  logic [36:0]           pd;
  logic [15:0]           rdata;
  logic                  irq;
  logic                  wake;
  int                    num_errors = 0;
  int                    n_compared = 0;
  int                    cycles     = 0;
  always #5 clk_in = ~clk_in;
  icn_top u_icn_top (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
    .pins_in(pins), .sleep_in(sleep_in), .pullup_en_out(pu), .pulldown_en_out(pd),
    .irq_out(irq), .wake_out(wake));
  icn_pins_model u_icn_pins_model (.clk_in(clk_in), .pullup_en_in(pu),
    .pulldown_en_in(pd), .press_in(press), .pins_out(pins));
  // ==========================================
  // Access tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    @(negedge clk_in);
    chk(48'(rdata), 48'(exp));
  endtask : rd
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 1000) begin
      num_errors++;
      complete_run();
    end
  end
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 11; a++) rd(8'(a), 16'h0000);
    rd(8'h20, 16'h0000);
    for (int a = 3; a < 6; a++) wr(8'(a), 16'hffff);
    rd(`ICN_OFS_LVL, 16'hffff);
    chk(48'(pu), 48'h1f_ffff_ffff);
    rd(8'h05, 16'h001f);
    wr(`ICN_OFS_MASK, 16'h0005);
    wr(`ICN_OFS_EN, 16'h0001);
    press[1:0] <= 2'h3;
    repeat (4) @(negedge clk_in);
    chk(48'(irq), 48'h1);
    rd(`ICN_OFS_STAT, 16'h0001);
    chk(48'(irq), 48'h0);
    @(negedge clk_in);
    chk(48'(rdata), 48'h0);
    @(posedge clk_in);
    press[1] <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(`ICN_OFS_STAT, 16'h0000);
    @(posedge clk_in);
    sleep_in <= 1'b1;
    @(posedge clk_in);
    press[0] <= 1'b0;
    @(negedge clk_in);
    chk(48'(wake), 48'h1);
    @(posedge clk_in);
    sleep_in <= 1'b0;
    @(negedge clk_in);
    chk(48'(wake), 48'h0);
    repeat (3) @(posedge clk_in);
    rd(`ICN_OFS_STAT, 16'h0003);
    wr(`ICN_OFS_PD, 16'h0001);
    wr(8'h08, 16'h001f);
    @(negedge clk_in);
    chk(48'(pd), 48'h1f_0000_0001);
    chk(48'(irq), 48'h1);
    rd(`ICN_OFS_STAT, 16'h0004);
    wr(8'h08, 16'h0000);
    wr(8'h05, 16'h0000);
    wr(`ICN_OFS_PD, 16'h0000);
    rd(`ICN_OFS_STAT, 16'h0004);
    rd(`ICN_OFS_STAT, 16'h0000);
    chk(48'(pu), 48'h00_ffff_ffff);
    chk(48'(pd), 48'h0);
    chk(48'(irq), 48'h0);
    complete_run();
  end
endmodule : tb_icn_top
`default_nettype wire
